/* File: acsr_pkg.sv */
// Shared constants, types and helpers for the conversion-mode serial readout
package acsr_pkg;

    // ========================================
    // Timing
    localparam int CLOCK_PERIOD_NS         = 40;
    localparam int CONVERSION_TIME_NS      = 600;
    localparam int CONVERSION_CYCLES       = (CONVERSION_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int CLOCK_TO_START_GAP_NS   = 80;
    localparam int CLOCK_TO_START_GAP_CYCLES = (CLOCK_TO_START_GAP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SCK_PERIOD_NS           = 320;
    localparam int SCK_HALF_CYCLES         = SCK_PERIOD_NS / (2 * CLOCK_PERIOD_NS);
    localparam int START_HIGH_NS           = 160;
    localparam int START_HIGH_CYCLES       = (START_HIGH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int RESET_PULSE_NS          = 400;
    localparam int RESET_PULSE_CYCLES      = (RESET_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SYNC_MARGIN_CYCLES      = 4;
    localparam int AUTOCYCLE_PERIOD0_NS    = 10000;
    localparam int AUTOCYCLE_PERIOD1_NS    = 20000;
    localparam int AUTOCYCLE_PERIOD2_NS    = 50000;
    localparam int AUTOCYCLE_PERIOD3_NS    = 100000;

    // ========================================
    // Frame layout
    localparam int RESULT_BITS             = 16;
    localparam int STATUS_BITS             = 8;
    localparam int FRAME_BITS_MAX          = 24;
    localparam int LANES                   = 4;
    localparam int CMD_BITS                = 5;
    localparam logic [4:0] SOFT_RESET_CMD  = 5'h1F;
    localparam logic [5:0] EDGE_SAT        = 6'h3F;
    localparam logic [3:0] CHANNEL_RESET   = 4'h0;

    typedef enum logic [1:0]
    {
        ACSR_LANE_SINGLE = 2'h0,
        ACSR_LANE_DUAL   = 2'h1,
        ACSR_LANE_QUAD   = 2'h2
    } acsr_lane_t;

    // ========================================
    // Helpers
    function automatic logic [5:0] acsr_frame_sck(input logic [1:0] lanes_log2, input logic status_on);
        logic [5:0] bits;
        bits = status_on ? 6'h18 : 6'h10;
        return bits >> lanes_log2;
    endfunction

    function automatic logic [11:0] acsr_autocycle_cycles(input logic [1:0] sel);
        int ns;
        case (sel)
            2'h0:    ns = AUTOCYCLE_PERIOD0_NS;
            2'h1:    ns = AUTOCYCLE_PERIOD1_NS;
            2'h2:    ns = AUTOCYCLE_PERIOD2_NS;
            default: ns = AUTOCYCLE_PERIOD3_NS;
        endcase
        return 12'((ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    endfunction

endpackage

/* File: acsr_if.sv */
// Link between the converter readout end and the host controller end
`timescale 1ns/10ps
interface acsr_if;
    logic       sck;
    logic       convert_start_input;
    logic       sdi;
    logic       hw_reset_n;
    logic [3:0] sdo;
    logic [3:0] sdo_oe;
    logic [3:0] sdo_line;
    logic       busy;

    // Released lanes read low at the host
    assign sdo_line = sdo & sdo_oe;

    modport device_end (input sck, input convert_start_input, input sdi, input hw_reset_n,
                        output sdo, output sdo_oe, output busy);
    modport host_end   (output sck, output convert_start_input, output sdi, output hw_reset_n,
                        input sdo_line, input busy);
endinterface

/* File: acsr_device.sv */
// Converter end: conversion timing, frame shifting, command capture and resets
// Overview of operation
// RULE1 - Result readable only until next conversion starts
// RULE2 - Host frames only after conversion, before gap
// RULE3 - Frame clock count equals bits over lanes
// RULE4 - Drive one, two or four lanes
// RULE5 - Four lanes only on variant with pins
// RULE6 - Frame is 16 bits, or 24 with status
// RULE7 - Channel switches after full 5-bit command
// RULE8 - Autocycle timer starts conversions by period select
// RULE9 - Autocycle host follows busy indicator edges
// RULE10 - Host may send extra clock periods
// RULE11 - Idle select 0 holds lanes after LSB
// RULE12 - Idle select 1 releases lanes after LSB
// RULE13 - Conversion mode clock period at least 12.5 ns
// RULE14 - Configuration mode clock period at least 40 ns
// RULE15 - Hardware reset input is active low
// RULE16 - Host idles reset high, pulses low
// RULE17 - Serial software reset command is offered
// RULE18 - Busy falls at conversion end, rises at start
// RULE19 - Edges beyond frame length count as extra
`timescale 1ns/10ps
module acsr_device
#(
    parameter bit QUAD_PINS = 1'b1
)
(
    input  wire logic                         clock,
    input  wire logic                         reset,
    acsr_if.device_end                        link,
    input  wire logic [acsr_pkg::RESULT_BITS-1:0] result,
    input  wire logic [acsr_pkg::STATUS_BITS-1:0] status,
    input  wire logic [1:0]                   lane_mode,
    input  wire logic                         status_enable,
    input  wire logic                         output_idle_select,
    input  wire logic                         autocycle_enable,
    input  wire logic [1:0]                   autocycle_period_select,
    output logic [3:0]                        mux_channel,
    output logic                              in_reset
);
    import acsr_pkg::*;

    typedef enum logic [1:0]
    {
        D_RESET   = 2'h0,
        D_CONVERT = 2'h1,
        D_READY   = 2'h2
    } acsr_dstate_t;

    // ========================================
    // Input synchronisers
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic       sck_last_reg;
    logic       cnv_last_reg;
    logic       sck_s;
    logic       cnv_s;
    logic       sdi_s;
    logic       rstn_s;

    always_ff @(posedge clock)
    begin
        sync1_reg    <= {link.hw_reset_n, link.sdi, link.convert_start_input, link.sck};
        sync2_reg    <= sync1_reg;
        sck_last_reg <= sync2_reg[0];
        cnv_last_reg <= sync2_reg[1];
    end

    assign sck_s  = sync2_reg[0];
    assign cnv_s  = sync2_reg[1];
    assign sdi_s  = sync2_reg[2];
    assign rstn_s = sync2_reg[3];

    // ========================================
    // Conversion and frame state
    acsr_dstate_t            state_reg,   state_next;
    logic [11:0]             timer_reg,   timer_next;
    logic [11:0]             ac_count_reg, ac_count_next;
    logic [FRAME_BITS_MAX-1:0] sr_reg,    sr_next;
    logic [5:0]              edge_reg,    edge_next;
    logic [1:0]              lanes_reg,   lanes_next;
    logic [5:0]              nsck_reg,    nsck_next;
    logic [4:0]              cmd_reg,     cmd_next;
    logic [2:0]              cmd_cnt_reg, cmd_cnt_next;
    logic                    soft_reg,    soft_next;
    logic [3:0]              chan_reg,    chan_next;
    logic [3:0]              sdo_reg,     sdo_next;
    logic [3:0]              oe_reg,      oe_next;
    logic                    busy_reg,    busy_next;
    logic                    in_reset_reg, in_reset_next;

    logic                    start_now;
    logic                    update_lanes;
    logic [1:0]              eff_lanes;
    logic [4:0]              cmd_full;

    always_comb
    begin
        state_next    = state_reg;
        timer_next    = timer_reg;
        ac_count_next = ac_count_reg;
        sr_next       = sr_reg;
        edge_next     = edge_reg;
        lanes_next    = lanes_reg;
        nsck_next     = nsck_reg;
        cmd_next      = cmd_reg;
        cmd_cnt_next  = cmd_cnt_reg;
        soft_next     = 1'b0;
        chan_next     = chan_reg;
        sdo_next      = sdo_reg;
        oe_next       = oe_reg;
        busy_next     = busy_reg;
        in_reset_next = 1'b0;
        update_lanes  = 1'b0;
        cmd_full      = {cmd_reg[3:0], sdi_s};

        // Quad request falls back to single lane without the extra pins
        if (lane_mode == ACSR_LANE_QUAD && QUAD_PINS)                     // [RULE5]
            eff_lanes = ACSR_LANE_QUAD;
        else if (lane_mode == ACSR_LANE_DUAL)
            eff_lanes = ACSR_LANE_DUAL;
        else
            eff_lanes = ACSR_LANE_SINGLE;

        // Internal convert start in autocycle mode
        start_now = cnv_s & ~cnv_last_reg;
        if (autocycle_enable && state_reg != D_RESET)
        begin
            if (ac_count_reg >= acsr_autocycle_cycles(autocycle_period_select) - 12'h001)  // [RULE8]
            begin
                ac_count_next = 12'h000;
                start_now     = 1'b1;
            end
            else
                ac_count_next = ac_count_reg + 12'h001;
        end
        else
            ac_count_next = 12'h000;

        case (state_reg)
            D_RESET:
            begin
                state_next = D_READY;
            end
            D_CONVERT:
            begin
                timer_next = timer_reg + 12'h001;
                if (timer_reg == 12'(CONVERSION_CYCLES - 1))
                begin
                    state_next   = D_READY;
                    busy_next    = 1'b0;                                  // [RULE18]
                    sr_next      = status_enable ? {result, status}
                                                 : {result, 8'h00};       // [RULE6]
                    lanes_next   = eff_lanes;
                    nsck_next    = acsr_frame_sck(eff_lanes, status_enable);  // [RULE3]
                    edge_next    = 6'h00;
                    cmd_cnt_next = 3'h0;
                    update_lanes = 1'b1;
                end
            end
            default:
            begin
                if (start_now)
                begin
                    // Old result is dropped once a new conversion begins
                    state_next = D_CONVERT;                               // [RULE1]
                    timer_next = 12'h000;
                    busy_next  = 1'b1;                                    // [RULE18]
                    oe_next    = 4'h0;
                end
                else
                begin
                    if (sck_s && !sck_last_reg && cmd_cnt_reg < 3'(CMD_BITS))
                    begin
                        cmd_next     = cmd_full;
                        cmd_cnt_next = cmd_cnt_reg + 3'h1;
                        if (cmd_cnt_reg == 3'(CMD_BITS - 1))
                        begin
                            if (cmd_full == SOFT_RESET_CMD)
                                soft_next = 1'b1;                         // [RULE17]
                            else if (!cmd_full[4])
                                chan_next = cmd_full[3:0];                // [RULE7]
                        end
                    end
                    if (!sck_s && sck_last_reg && nsck_reg != 6'h00)
                    begin
                        if (edge_reg != EDGE_SAT)
                            edge_next = edge_reg + 6'h01;
                        if ({1'b0, edge_reg} + 7'h01 < {1'b0, nsck_reg})
                        begin
                            sr_next      = sr_reg << (3'h1 << lanes_reg); // [RULE4]
                            update_lanes = 1'b1;
                        end
                        else if ({1'b0, edge_reg} + 7'h01 > {1'b0, nsck_reg})  // [RULE19]
                        begin
                            if (output_idle_select)
                                oe_next = 4'h0;                           // [RULE12]
                            else
                                oe_next = oe_reg;                         // [RULE11]
                        end
                    end
                end
            end
        endcase

        if (update_lanes)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (i < (1 << lanes_next))
                begin
                    sdo_next[i] = sr_next[FRAME_BITS_MAX-1-i];           // [RULE4]
                    oe_next[i]  = 1'b1;
                end
                else
                begin
                    sdo_next[i] = 1'b0;
                    oe_next[i]  = 1'b0;
                end
            end
        end

        if (reset || !rstn_s || soft_reg)                                 // [RULE15] [RULE17]
        begin
            state_next    = D_RESET;
            timer_next    = 12'h000;
            ac_count_next = 12'h000;
            sr_next       = '0;
            edge_next     = 6'h00;
            lanes_next    = ACSR_LANE_SINGLE;
            nsck_next     = 6'h00;
            cmd_next      = 5'h00;
            cmd_cnt_next  = 3'h0;
            soft_next     = 1'b0;
            chan_next     = CHANNEL_RESET;
            sdo_next      = 4'h0;
            oe_next       = 4'h0;
            busy_next     = 1'b0;
            in_reset_next = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        state_reg    <= state_next;
        timer_reg    <= timer_next;
        ac_count_reg <= ac_count_next;
        sr_reg       <= sr_next;
        edge_reg     <= edge_next;
        lanes_reg    <= lanes_next;
        nsck_reg     <= nsck_next;
        cmd_reg      <= cmd_next;
        cmd_cnt_reg  <= cmd_cnt_next;
        soft_reg     <= soft_next;
        chan_reg     <= chan_next;
        sdo_reg      <= sdo_next;
        oe_reg       <= oe_next;
        busy_reg     <= busy_next;
        in_reset_reg <= in_reset_next;
    end

    assign link.sdo    = sdo_reg;
    assign link.sdo_oe = oe_reg;
    assign link.busy   = busy_reg;
    assign mux_channel = chan_reg;
    assign in_reset    = in_reset_reg;

endmodule // acsr_device

/* File: acsr_host.sv */
// Host end: convert start, reset pulse, serial clock and frame capture
`timescale 1ns/10ps
module acsr_host
(
    input  wire logic        clock,
    input  wire logic        reset,
    acsr_if.host_end         link,
    input  wire logic        start_read,
    input  wire logic        use_busy,
    input  wire logic [1:0]  lane_mode,
    input  wire logic        status_enable,
    input  wire logic [4:0]  command,
    input  wire logic        hw_reset_request,
    output logic [23:0]      read_data,
    output logic             read_valid,
    output logic             host_ready
);
    import acsr_pkg::*;

    typedef enum logic [2:0]
    {
        H_IDLE  = 3'h0,
        H_PULSE = 3'h1,
        H_CNV   = 3'h2,
        H_WAIT  = 3'h3,
        H_FRAME = 3'h4,
        H_GAP   = 3'h5
    } acsr_hstate_t;

    // ========================================
    // Input synchronisers
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic       busy_last_reg;

    always_ff @(posedge clock)
    begin
        sync1_reg     <= {link.busy, link.sdo_line};
        sync2_reg     <= sync1_reg;
        busy_last_reg <= sync2_reg[4];
    end

    // ========================================
    // Frame sequencing
    acsr_hstate_t state_reg,  state_next;
    logic [11:0]  cnt_reg,    cnt_next;
    logic [5:0]   per_reg,    per_next;
    logic [5:0]   nsck_reg,   nsck_next;
    logic [1:0]   lanes_reg,  lanes_next;
    logic [4:0]   cmd_reg,    cmd_next;
    logic         wait_busy_reg, wait_busy_next;
    logic [23:0]  rx_reg,     rx_next;
    logic         sck_reg,    sck_next;
    logic         cnv_reg,    cnv_next;
    logic         sdi_reg,    sdi_next;
    logic         rstn_reg,   rstn_next;
    logic         valid_reg,  valid_next;
    logic         ready_reg,  ready_next;
    logic [1:0]   req_lanes;

    always_comb
    begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        per_next       = per_reg;
        nsck_next      = nsck_reg;
        lanes_next     = lanes_reg;
        cmd_next       = cmd_reg;
        wait_busy_next = wait_busy_reg;
        rx_next        = rx_reg;
        sck_next       = sck_reg;
        cnv_next       = cnv_reg;
        sdi_next       = sdi_reg;
        rstn_next      = 1'b1;                                           // [RULE16]
        valid_next     = 1'b0;
        ready_next     = 1'b0;
        req_lanes      = (lane_mode == ACSR_LANE_QUAD) ? ACSR_LANE_QUAD :
                         (lane_mode == ACSR_LANE_DUAL) ? ACSR_LANE_DUAL : ACSR_LANE_SINGLE;

        case (state_reg)
            H_IDLE:
            begin
                ready_next = 1'b1;
                if (hw_reset_request)
                begin
                    state_next = H_PULSE;
                    cnt_next   = 12'h000;
                    rstn_next  = 1'b0;
                    ready_next = 1'b0;
                end
                else if (start_read)
                begin
                    lanes_next     = req_lanes;
                    nsck_next      = acsr_frame_sck(req_lanes, status_enable);  // [RULE3]
                    cmd_next       = command;
                    wait_busy_next = use_busy;
                    cnt_next       = 12'h000;
                    ready_next     = 1'b0;
                    state_next     = use_busy ? H_WAIT : H_CNV;
                    cnv_next       = ~use_busy;
                end
            end
            H_PULSE:
            begin
                cnt_next  = cnt_reg + 12'h001;
                rstn_next = 1'b0;
                if (cnt_reg == 12'(RESET_PULSE_CYCLES - 1))
                begin
                    rstn_next  = 1'b1;
                    state_next = H_GAP;
                    cnt_next   = 12'h000;
                end
            end
            H_CNV:
            begin
                cnt_next = cnt_reg + 12'h001;
                if (cnt_reg == 12'(START_HIGH_CYCLES - 1))
                begin
                    cnv_next   = 1'b0;
                    cnt_next   = 12'h000;
                    state_next = H_WAIT;
                end
            end
            H_WAIT:
            begin
                cnt_next = cnt_reg + 12'h001;
                // Autocycle follows busy, otherwise wait out the longest conversion
                if ((wait_busy_reg && busy_last_reg && !sync2_reg[4]) ||  // [RULE9]
                    (!wait_busy_reg &&
                     cnt_reg == 12'(CONVERSION_CYCLES + SYNC_MARGIN_CYCLES - 1)))  // [RULE2]
                begin
                    state_next = H_FRAME;
                    cnt_next   = 12'h000;
                    per_next   = 6'h00;
                    sck_next   = 1'b1;
                    sdi_next   = cmd_reg[4];
                    rx_next    = 24'h000000;
                end
            end
            H_FRAME:
            begin
                cnt_next = cnt_reg + 12'h001;
                if (cnt_reg == 12'(SCK_HALF_CYCLES - 1))
                begin
                    // Falling edge: capture the bits presented before it
                    sck_next = 1'b0;
                    for (int i = 0; i < LANES; i++)
                    begin
                        if (i < (1 << lanes_reg))
                            rx_next = {rx_next[22:0], sync2_reg[i]};     // [RULE4]
                    end
                    cmd_next = {cmd_reg[3:0], 1'b0};
                    sdi_next = cmd_reg[3];
                    per_next = per_reg + 6'h01;
                end
                else if (cnt_reg == 12'(2 * SCK_HALF_CYCLES - 1))
                begin
                    cnt_next = 12'h000;
                    if (per_reg == nsck_reg)                              // [RULE3]
                    begin
                        state_next = H_GAP;
                        valid_next = 1'b1;
                        sdi_next   = 1'b0;
                    end
                    else
                        sck_next = 1'b1;                                  // [RULE13] [RULE14]
                end
            end
            default:
            begin
                cnt_next = cnt_reg + 12'h001;
                if (cnt_reg == 12'(CLOCK_TO_START_GAP_CYCLES - 1))        // [RULE2]
                begin
                    state_next = H_IDLE;
                    ready_next = 1'b1;
                end
            end
        endcase

        if (reset)
        begin
            state_next     = H_IDLE;
            cnt_next       = 12'h000;
            per_next       = 6'h00;
            nsck_next      = 6'h00;
            lanes_next     = ACSR_LANE_SINGLE;
            cmd_next       = 5'h00;
            wait_busy_next = 1'b0;
            rx_next        = 24'h000000;
            sck_next       = 1'b0;
            cnv_next       = 1'b0;
            sdi_next       = 1'b0;
            rstn_next      = 1'b1;
            valid_next     = 1'b0;
            ready_next     = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        state_reg     <= state_next;
        cnt_reg       <= cnt_next;
        per_reg       <= per_next;
        nsck_reg      <= nsck_next;
        lanes_reg     <= lanes_next;
        cmd_reg       <= cmd_next;
        wait_busy_reg <= wait_busy_next;
        rx_reg        <= rx_next;
        sck_reg       <= sck_next;
        cnv_reg       <= cnv_next;
        sdi_reg       <= sdi_next;
        rstn_reg      <= rstn_next;
        valid_reg     <= valid_next;
        ready_reg     <= ready_next;
    end

    assign link.sck                 = sck_reg;
    assign link.convert_start_input = cnv_reg;
    assign link.sdi                 = sdi_reg;
    assign link.hw_reset_n          = rstn_reg;
    assign read_data                = rx_reg;
    assign read_valid               = valid_reg;
    assign host_ready               = ready_reg;

endmodule // acsr_host

/* File: acsr_props.sv */
// Link assertions for the conversion-mode serial readout
`timescale 1ns/10ps
module acsr_props
(
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       sck,
    input wire logic       convert_start_input,
    input wire logic       hw_reset_n,
    input wire logic [3:0] sdo_oe,
    input wire logic       busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // ========================================
    // Properties
    property p_quiet_busy; busy |-> sdo_oe == 4'h0; endproperty
    a_quiet_busy: assert property (p_quiet_busy) else $error("lanes driven in conversion");
    property p_start; $rose(convert_start_input) |-> ##[1:4] $rose(busy); endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_busy_len; $rose(busy) |-> ##14 busy ##1 !busy; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_data_up; $fell(busy) |-> sdo_oe != 4'h0; endproperty
    a_data_up: assert property (p_data_up) else $error("no lanes after conversion");
    property p_no_clk; sck |-> !busy; endproperty
    a_no_clk: assert property (p_no_clk) else $error("clock during conversion");
    property p_half; $rose(sck) |-> sck[*4] ##1 !sck; endproperty
    a_half: assert property (p_half) else $error("clock half period wrong");
    property p_pulse; $fell(hw_reset_n) |-> !hw_reset_n[*8]; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse short");
    property p_hw_rst; $fell(hw_reset_n) |-> ##[2:5] (sdo_oe == 4'h0 && !busy); endproperty
    a_hw_rst: assert property (p_hw_rst) else $error("hardware reset not taken");
    c_done: cover property ($fell(busy));
    c_quad: cover property ($rose(sck) && sdo_oe == 4'hF);
    c_reset: cover property ($fell(hw_reset_n));
endmodule // acsr_props

/* File: adc_conversion_spi_readout_tb.sv */
// Testbench joining both ends of the readout link
`timescale 1ns/10ps
module adc_conversion_spi_readout_tb;
    import acsr_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] result = 16'h0000;
    logic [7:0]  status = 8'h5A;
    logic [1:0]  dev_lane = 2'h0;
    logic [1:0]  host_lane = 2'h0;
    logic        stat_en = 1'b0;
    logic        idle_sel = 1'b0;
    logic        auto_en = 1'b0;
    logic [1:0]  auto_sel = 2'h0;
    logic        start_read = 1'b0;
    logic        use_busy = 1'b0;
    logic [4:0]  command = 5'h10;
    logic        hw_req = 1'b0;
    logic [23:0] read_data;
    logic        read_valid;
    logic        host_ready;
    logic [3:0]  mux_channel;
    logic        in_reset;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          k;
    int          a;
    int          b;
    always #20 clock = ~clock;
    // ========================================
    // Instances
    acsr_if link();
    acsr_device acsr_device_i (.clock(clock), .reset(reset), .link(link), .result(result), .status(status),
        .lane_mode(dev_lane), .status_enable(stat_en), .output_idle_select(idle_sel), .autocycle_enable(auto_en),
        .autocycle_period_select(auto_sel), .mux_channel(mux_channel), .in_reset(in_reset));
    acsr_host acsr_host_i (.clock(clock), .reset(reset), .link(link), .start_read(start_read),
        .use_busy(use_busy), .lane_mode(host_lane), .status_enable(stat_en), .command(command),
        .hw_reset_request(hw_req), .read_data(read_data), .read_valid(read_valid), .host_ready(host_ready));
    acsr_props acsr_props_i (.clock(clock), .reset(reset), .sck(link.sck),
        .convert_start_input(link.convert_start_input), .hw_reset_n(link.hw_reset_n), .sdo_oe(link.sdo_oe),
        .busy(link.busy));
    // ========================================
    // Tasks
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic read_frame(input logic [1:0] hl, input logic [4:0] cmd);
        int w;
        for (w = 0; w < 900 && host_ready !== 1'b1; w++)
            @(posedge clock);
        host_lane <= hl;
        command <= cmd;
        start_read <= 1'b1;
        @(posedge clock);
        start_read <= 1'b0;
        for (w = 0; w < 900 && read_valid !== 1'b1; w++)
            @(posedge clock);
        check({23'h0, read_valid}, 24'h000001);
    endtask
    // ========================================
    // Sequence
    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        repeat (6) @(posedge clock);
        check({23'h0, in_reset}, 24'h000000);
        for (k = 0; k < 6; k++)
        begin
            dev_lane <= 2'(k % 3);
            stat_en <= k > 2;
            result <= 16'hA5C3 + 16'(k);
            read_frame(2'(k % 3), 5'h10);
            check(read_data, (k > 2) ? {16'hA5C3 + 16'(k), 8'h5A} : {8'h00, 16'hA5C3 + 16'(k)});
        end
        dev_lane <= 2'h0;
        stat_en <= 1'b0;
        read_frame(2'h0, 5'h03);
        check({20'h0, mux_channel}, 24'h000003);
        read_frame(2'h0, 5'h1F);
        check({20'h0, mux_channel}, 24'h000000);
        read_frame(2'h0, 5'h05);
        check({20'h0, mux_channel}, 24'h000005);
        repeat (4) @(posedge clock);
        hw_req <= 1'b1;
        @(posedge clock);
        hw_req <= 1'b0;
        repeat (8) @(posedge clock);
        check({23'h0, in_reset}, 24'h000001);
        repeat (22) @(posedge clock);
        check({20'h0, mux_channel}, 24'h000000);
        for (k = 0; k < 2; k++)
        begin
            idle_sel <= k[0];
            dev_lane <= 2'h2;
            read_frame(2'h0, 5'h10);
            repeat (4) @(posedge clock);
            check({20'h0, link.sdo_oe}, (k == 1) ? 24'h0 : 24'hF);
        end
        auto_en <= 1'b1;
        use_busy <= 1'b1;
        result <= 16'hBEEF;
        read_frame(2'h2, 5'h10);
        check(read_data, 24'h00BEEF);
        for (k = 0; k < 2; k++)
        begin
            auto_sel <= 2'(k);
            repeat (3)
            begin
                for (a = 0; a < 3000 && link.busy !== 1'b0; a++)
                    @(posedge clock);
                for (b = 0; b < 3000 && link.busy !== 1'b1; b++)
                    @(posedge clock);
            end
            check(24'(a + b), 24'((k == 1 ? AUTOCYCLE_PERIOD1_NS : AUTOCYCLE_PERIOD0_NS) / CLOCK_PERIOD_NS));
        end
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        test_done();
    end
endmodule // adc_conversion_spi_readout_tb
